// *** logic/light_sensor_pkg.sv ***
// Constants for the gain, identification and status register bank.
// Assumes a serial bus engine on the same clock that presents register accesses.
package light_sensor_pkg;

  // ---------------------------------------------------------------
  // Register offsets
  // ---------------------------------------------------------------
  localparam logic [7:0] GAIN_RANGE_ADDR  = 8'h05;
  localparam logic [7:0] DEVICE_ID_ADDR   = 8'h06;
  localparam logic [7:0] STATUS_ADDR      = 8'h07;
  localparam logic [7:0] FREEZE_LO_ADDR   = 8'h07;
  localparam logic [7:0] FREEZE_HI_ADDR   = 8'h12;
  localparam logic [7:0] DATA_LO_ADDR     = 8'h0D;
  localparam logic [7:0] DATA_HI_ADDR     = 8'h12;

  // ---------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------
  localparam logic [7:0] GAIN_RESET       = 8'h01;
  localparam logic [7:0] STATUS_RESET     = 8'h20;

  // ---------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------
  localparam int GAIN_FIELD_MSB           = 2;
  localparam int GAIN_FIELD_LSB           = 0;
  localparam int ID_PRODUCT_MSB           = 7;
  localparam int ID_PRODUCT_LSB           = 4;
  localparam int ID_REVISION_MSB          = 3;
  localparam int ID_REVISION_LSB          = 0;
  localparam int STATUS_POWER_ON_BIT      = 5;
  localparam int STATUS_IRQ_BIT           = 4;
  localparam int STATUS_NEW_DATA_BIT      = 3;

  // ---------------------------------------------------------------
  // Gain codes and factors
  // ---------------------------------------------------------------
  localparam logic [2:0] GAIN_CODE_X1     = 3'h0;
  localparam logic [2:0] GAIN_CODE_X3     = 3'h1;
  localparam logic [2:0] GAIN_CODE_X6     = 3'h2;
  localparam logic [2:0] GAIN_CODE_X9     = 3'h3;
  localparam logic [2:0] GAIN_CODE_X18    = 3'h4;
  localparam logic [4:0] GAIN_FACTOR_X1   = 5'h01;
  localparam logic [4:0] GAIN_FACTOR_X3   = 5'h03;
  localparam logic [4:0] GAIN_FACTOR_X6   = 5'h06;
  localparam logic [4:0] GAIN_FACTOR_X9   = 5'h09;
  localparam logic [4:0] GAIN_FACTOR_X18  = 5'h12;

  // ---------------------------------------------------------------
  // Channels
  // ---------------------------------------------------------------
  localparam int CHAN_COUNT               = 2;
  localparam int CHAN_VISIBLE             = 0;
  localparam int CHAN_UV                  = 1;

endpackage

// *** logic/light_sensor_regs.sv ***
// Gain range, identification and status registers of the light sensor.
// Assumes register accesses and measurement events come from logic on SYS_CLK_IN.
// Assumes READ_ACTIVE_IN spans a whole serial read and MEAS_DONE_IN pulses once.
// Thresholds, persistence and enable are held by registers outside this block.
`timescale 1ns/1ps
`default_nettype none

// Functional notes
// R1 - The 3-bit gain code selects gain 1, 3, 6, 9 or 18 for codes 000 to 100.
// R2 - The gain register resets to 0x01 and its bits 7:3 always read zero.
// R3 - The identification register is read-only with product in 7:4 and revision in 3:0.
// R4 - The revision field is raised by one for each new silicon revision.
// R5 - After power-on the status power-on flag in bit 5 reads 1.
// R6 - A status read clears the power-on flag.
// R7 - With the threshold interrupt on, data above the upper or below the lower limit sets bit 4.
// R8 - Bit 4 is set only after the out-of-range condition holds for the persistence count.
// R9 - Bit 4 stays set until a status read clears it.
// R10 - Bit 3 is set by a new unread result and cleared by a status read.
// R11 - Bit 3 reads 0 once the held measurement data has been read.
// R12 - The status register resets to 0x20 with its reserved bits at zero.
// R13 - During a serial read into 0x07 to 0x12 the visible data freezes and new results wait.
// R14 - The threshold interrupt is produced only while its enable is 1.
// R15 - The persistence count is the number of out-of-range results before the interrupt.
// R16 - A status read returns the flags as they stood and then clears them, losing no new event.
// R17 - Writes to the identification and status registers are ignored.
module light_sensor_regs
  import light_sensor_pkg::*;
#(
  parameter int         DATA_WIDTH    = 20,
  parameter int         PERSIST_WIDTH = 4,
  // Arbitrary neutral identity values
  parameter logic [3:0] PRODUCT_ID    = 4'h5,
  parameter logic [3:0] REVISION_ID   = 4'h1
) (
  input  wire logic                     SYS_CLK_IN,
  input  wire logic                     ARST_N_IN,
  input  wire logic [7:0]               REG_ADDR_IN,
  input  wire logic                     REG_WR_IN,
  input  wire logic [7:0]               REG_WDATA_IN,
  input  wire logic                     REG_RD_IN,
  input  wire logic                     READ_ACTIVE_IN,
  input  wire logic                     MEAS_DONE_IN,
  input  wire logic [DATA_WIDTH-1:0]    MEAS_VISIBLE_IN,
  input  wire logic [DATA_WIDTH-1:0]    MEAS_UV_IN,
  input  wire logic                     IRQ_SELECT_UV_IN,
  input  wire logic                     THRESHOLD_IRQ_ENABLE_IN,
  input  wire logic [PERSIST_WIDTH-1:0] IRQ_PERSISTENCE_IN,
  input  wire logic [DATA_WIDTH-1:0]    THRESH_UPPER_IN,
  input  wire logic [DATA_WIDTH-1:0]    THRESH_LOWER_IN,
  output logic      [7:0]               REG_RDATA_OUT,
  output logic      [2:0]               GAIN_CODE_OUT,
  output logic      [4:0]               GAIN_FACTOR_OUT,
  output logic      [DATA_WIDTH-1:0]    VISIBLE_DATA_OUT,
  output logic      [DATA_WIDTH-1:0]    UV_DATA_OUT,
  output logic                          IRQ_FLAG_OUT,
  output logic                          NEW_DATA_OUT
);

  // ---------------------------------------------------------------
  // Access decode
  // ---------------------------------------------------------------
  logic                     status_rd;
  logic                     data_rd;
  logic                     gain_wr;
  logic                     freeze;
  logic                     publish;
  logic [DATA_WIDTH-1:0]    meas [CHAN_COUNT];

  assign status_rd = REG_RD_IN && (REG_ADDR_IN == STATUS_ADDR);
  assign data_rd   = REG_RD_IN && (REG_ADDR_IN >= DATA_LO_ADDR)
                     && (REG_ADDR_IN <= DATA_HI_ADDR);
  // Identification and status have no write path at all
  assign gain_wr   = REG_WR_IN && (REG_ADDR_IN == GAIN_RANGE_ADDR); // R17
  // Pointer range, not the read strobe, decides the freeze
  assign freeze    = READ_ACTIVE_IN && (REG_ADDR_IN >= FREEZE_LO_ADDR)
                     && (REG_ADDR_IN <= FREEZE_HI_ADDR); // R13
  assign meas[CHAN_VISIBLE] = MEAS_VISIBLE_IN;
  assign meas[CHAN_UV]      = MEAS_UV_IN;

  // ---------------------------------------------------------------
  // Gain range register
  // ---------------------------------------------------------------
  logic [2:0] gain_q;
  logic [2:0] gain_d;
  logic [4:0] factor_q;
  logic [4:0] factor_d;

  always_comb begin
    gain_d = gain_q;
    // Reserved codes above 100 are dropped so the factor stays defined
    if (gain_wr && (REG_WDATA_IN[GAIN_FIELD_MSB:GAIN_FIELD_LSB] <= GAIN_CODE_X18)) begin
      gain_d = REG_WDATA_IN[GAIN_FIELD_MSB:GAIN_FIELD_LSB];
    end
    // Factor follows the next code so both registers move together
    unique case (gain_d) // R1
      GAIN_CODE_X1:  factor_d = GAIN_FACTOR_X1;
      GAIN_CODE_X3:  factor_d = GAIN_FACTOR_X3;
      GAIN_CODE_X6:  factor_d = GAIN_FACTOR_X6;
      GAIN_CODE_X9:  factor_d = GAIN_FACTOR_X9;
      GAIN_CODE_X18: factor_d = GAIN_FACTOR_X18;
      default:       factor_d = GAIN_FACTOR_X3;
    endcase
  end

  always_ff @(posedge SYS_CLK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      gain_q   <= GAIN_RESET[GAIN_FIELD_MSB:GAIN_FIELD_LSB]; // R2
      factor_q <= GAIN_FACTOR_X3;
    end else begin
      gain_q   <= gain_d;
      factor_q <= factor_d;
    end
  end

  // ---------------------------------------------------------------
  // Measurement staging and freeze
  // ---------------------------------------------------------------
  logic pend_q;
  logic pend_d;

  // A fresh result while unfrozen supersedes anything still waiting
  assign publish = !freeze && (MEAS_DONE_IN || pend_q); // R13

  always_comb begin
    pend_d = pend_q;
    if (MEAS_DONE_IN && freeze) begin
      pend_d = 1'b1;
    end else if (publish) begin
      pend_d = 1'b0;
    end
  end

  always_ff @(posedge SYS_CLK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      pend_q <= 1'b0;
    end else begin
      pend_q <= pend_d;
    end
  end

  // Stage keeps only the newest frozen result
  logic [DATA_WIDTH-1:0] shown_q [CHAN_COUNT];

  for (genvar ch = 0; ch < CHAN_COUNT; ch++) begin : g_chan
    logic [DATA_WIDTH-1:0] stage_q;
    logic [DATA_WIDTH-1:0] stage_d;
    logic [DATA_WIDTH-1:0] shown_d;

    always_comb begin
      stage_d = stage_q;
      shown_d = shown_q[ch];
      if (MEAS_DONE_IN && freeze) begin
        stage_d = meas[ch]; // R13
      end else if (MEAS_DONE_IN) begin
        shown_d = meas[ch];
      end else if (publish) begin
        shown_d = stage_q;
      end
    end

    always_ff @(posedge SYS_CLK_IN or negedge ARST_N_IN) begin
      if (!ARST_N_IN) begin
        stage_q     <= '0;
        shown_q[ch] <= '0;
      end else begin
        stage_q     <= stage_d;
        shown_q[ch] <= shown_d;
      end
    end
  end

  // ---------------------------------------------------------------
  // Threshold persistence
  // ---------------------------------------------------------------
  logic [DATA_WIDTH-1:0]  sel_data;
  logic                   out_of_range;
  logic                   irq_event;
  logic [PERSIST_WIDTH:0] persist_q;
  logic [PERSIST_WIDTH:0] persist_d;

  // Raw results feed the compare, so a frozen view never delays the flag
  assign sel_data     = IRQ_SELECT_UV_IN ? MEAS_UV_IN : MEAS_VISIBLE_IN;
  assign out_of_range = (sel_data > THRESH_UPPER_IN) || (sel_data < THRESH_LOWER_IN); // R7
  // Fires on the result that makes the run exceed the persistence setting
  assign irq_event    = MEAS_DONE_IN && THRESHOLD_IRQ_ENABLE_IN && out_of_range
                        && (persist_q >= {1'b0, IRQ_PERSISTENCE_IN}); // R8 R14 R15

  always_comb begin
    persist_d = persist_q;
    if (MEAS_DONE_IN) begin
      if (THRESHOLD_IRQ_ENABLE_IN && out_of_range) begin // R15
        // Saturates so a long run never wraps back below the setting
        if (persist_q != {(PERSIST_WIDTH+1){1'b1}}) begin
          persist_d = persist_q + 1'b1;
        end
      end else begin
        persist_d = '0;
      end
    end
  end

  always_ff @(posedge SYS_CLK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      persist_q <= '0;
    end else begin
      persist_q <= persist_d;
    end
  end

  // ---------------------------------------------------------------
  // Status flags
  // ---------------------------------------------------------------
  logic power_on_q;
  logic power_on_d;
  logic irq_q;
  logic irq_d;
  logic new_q;
  logic new_d;
  logic flag_clr;
  logic new_clr;

  // Data reads retire new data but leave the event flags alone
  assign flag_clr = status_rd; // R6 R9
  assign new_clr  = status_rd || data_rd; // R10 R11

  always_comb begin
    power_on_d = power_on_q && !flag_clr; // R6
    // Set terms come last so an event in the clearing cycle survives
    irq_d      = (irq_q && !flag_clr) || irq_event; // R9 R16
    new_d      = (new_q && !new_clr) || publish; // R10 R11 R16
  end

  always_ff @(posedge SYS_CLK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      // Only the power-on flag leaves reset set
      power_on_q <= STATUS_RESET[STATUS_POWER_ON_BIT]; // R5 R12
      irq_q      <= STATUS_RESET[STATUS_IRQ_BIT]; // R12
      new_q      <= STATUS_RESET[STATUS_NEW_DATA_BIT]; // R12
    end else begin
      power_on_q <= power_on_d;
      irq_q      <= irq_d;
      new_q      <= new_d;
    end
  end

  // ---------------------------------------------------------------
  // Read data
  // ---------------------------------------------------------------
  logic [7:0] rdata_q;
  logic [7:0] rdata_d;
  logic [7:0] gain_word;
  logic [7:0] id_word;
  logic [7:0] status_word;

  // Word assembly kept apart from the capture below
  always_comb begin
    gain_word = 8'h00; // R2
    gain_word[GAIN_FIELD_MSB:GAIN_FIELD_LSB] = gain_q;
    id_word = 8'h00;
    id_word[ID_PRODUCT_MSB:ID_PRODUCT_LSB]   = PRODUCT_ID; // R3
    id_word[ID_REVISION_MSB:ID_REVISION_LSB] = REVISION_ID; // R4
    status_word = 8'h00; // R12
    status_word[STATUS_POWER_ON_BIT] = power_on_q;
    status_word[STATUS_IRQ_BIT]      = irq_q;
    status_word[STATUS_NEW_DATA_BIT] = new_q;
  end

  always_comb begin
    rdata_d = rdata_q;
    // Captured from the pre-clear flags, so the read shows what it clears
    if (REG_RD_IN) begin
      unique case (REG_ADDR_IN)
        GAIN_RANGE_ADDR: rdata_d = gain_word;
        DEVICE_ID_ADDR:  rdata_d = id_word;
        STATUS_ADDR:     rdata_d = status_word; // R16
        default:         rdata_d = 8'h00;
      endcase
    end
  end

  always_ff @(posedge SYS_CLK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      rdata_q <= 8'h00;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  assign REG_RDATA_OUT    = rdata_q;
  assign GAIN_CODE_OUT    = gain_q;
  // Factor leaves as a register so no decode glitch reaches the gain stage
  assign GAIN_FACTOR_OUT  = factor_q;
  assign VISIBLE_DATA_OUT = shown_q[CHAN_VISIBLE];
  assign UV_DATA_OUT      = shown_q[CHAN_UV];
  assign IRQ_FLAG_OUT     = irq_q;
  assign NEW_DATA_OUT     = new_q;

endmodule

`default_nettype wire

// *** bench/light_sensor_sva.sv ***
// Assertions on the gain, identity and status register bank.
// Bound to light_sensor_regs and sees only its ports.
`timescale 1ns/1ps
`default_nettype none
module light_sensor_sva
  import light_sensor_pkg::*;
#(
  parameter int         DATA_WIDTH  = 20,
  parameter logic [3:0] PRODUCT_ID  = 4'h5,
  parameter logic [3:0] REVISION_ID = 4'h1
) (
  input wire logic                  SYS_CLK_IN,
  input wire logic                  ARST_N_IN,
  input wire logic [7:0]            REG_ADDR_IN,
  input wire logic                  REG_WR_IN,
  input wire logic [7:0]            REG_WDATA_IN,
  input wire logic                  REG_RD_IN,
  input wire logic                  READ_ACTIVE_IN,
  input wire logic                  MEAS_DONE_IN,
  input wire logic [DATA_WIDTH-1:0] MEAS_VISIBLE_IN,
  input wire logic                  THRESHOLD_IRQ_ENABLE_IN,
  input wire logic [7:0]            REG_RDATA_OUT,
  input wire logic [2:0]            GAIN_CODE_OUT,
  input wire logic [4:0]            GAIN_FACTOR_OUT,
  input wire logic [DATA_WIDTH-1:0] VISIBLE_DATA_OUT,
  input wire logic                  IRQ_FLAG_OUT,
  input wire logic                  NEW_DATA_OUT
);
  // ---------------------------------------------------------------
  // Properties
  // ---------------------------------------------------------------
  default clocking @(posedge SYS_CLK_IN); endclocking
  default disable iff (!ARST_N_IN);
  logic frz;
  logic st_rd;
  assign frz   = READ_ACTIVE_IN && REG_ADDR_IN >= FREEZE_LO_ADDR && REG_ADDR_IN <= FREEZE_HI_ADDR;
  assign st_rd = REG_RD_IN && REG_ADDR_IN == STATUS_ADDR;
  chk_factor_map: assert property ({GAIN_CODE_OUT, GAIN_FACTOR_OUT} inside
    {8'h01, 8'h23, 8'h46, 8'h69, 8'h92}) else $error("gain factor wrong");
  chk_gain_write: assert property (REG_WR_IN && REG_ADDR_IN == GAIN_RANGE_ADDR &&
    REG_WDATA_IN[2:0] <= 3'h4 |=> {5'h00, GAIN_CODE_OUT} == ($past(REG_WDATA_IN) & 8'h07))
    else $error("gain write lost");
  chk_gain_keep: assert property (!(REG_WR_IN && REG_ADDR_IN == GAIN_RANGE_ADDR &&
    REG_WDATA_IN[2:0] <= 3'h4) |=> $stable(GAIN_CODE_OUT)) else $error("gain changed");
  chk_gain_read: assert property (REG_RD_IN && REG_ADDR_IN == GAIN_RANGE_ADDR |=>
    REG_RDATA_OUT == {5'h00, $past(GAIN_CODE_OUT)}) else $error("gain read wrong");
  chk_id_read: assert property (REG_RD_IN && REG_ADDR_IN == DEVICE_ID_ADDR |=>
    REG_RDATA_OUT == {PRODUCT_ID, REVISION_ID}) else $error("id read wrong");
  chk_status_snap: assert property (st_rd |=> REG_RDATA_OUT[7:6] == 2'h0 &&
    REG_RDATA_OUT[2:0] == 3'h0 && REG_RDATA_OUT[4:3] == {$past(IRQ_FLAG_OUT),
    $past(NEW_DATA_OUT)}) else $error("status read wrong");
  chk_irq_clear: assert property (st_rd && !MEAS_DONE_IN |=> !IRQ_FLAG_OUT)
    else $error("irq not cleared");
  chk_irq_hold: assert property (IRQ_FLAG_OUT && !st_rd |=> IRQ_FLAG_OUT)
    else $error("irq dropped");
  chk_irq_enable: assert property (!IRQ_FLAG_OUT && !(MEAS_DONE_IN &&
    THRESHOLD_IRQ_ENABLE_IN) |=> !IRQ_FLAG_OUT) else $error("irq without cause");
  chk_data_new: assert property (MEAS_DONE_IN && !frz |=> NEW_DATA_OUT &&
    VISIBLE_DATA_OUT == $past(MEAS_VISIBLE_IN)) else $error("data not published");
  chk_data_frozen: assert property (frz ##1 frz |=> $stable(VISIBLE_DATA_OUT))
    else $error("data moved while frozen");
endmodule
bind light_sensor_regs light_sensor_sva #(.DATA_WIDTH(DATA_WIDTH), .PRODUCT_ID(PRODUCT_ID),
  .REVISION_ID(REVISION_ID)) u_light_sensor_sva (.*);
`default_nettype wire

// *** bench/host_bus_model.sv ***
// Host side model issuing byte register accesses.
// Assumes read data is registered one cycle after the strobe edge.
`timescale 1ns/1ps
`default_nettype none
module host_bus_model (
  input  wire logic       clk_in,
  input  wire logic [7:0] rdata_in,
  output var  logic [7:0] addr_out,
  output var  logic       wr_out,
  output var  logic [7:0] wdata_out,
  output var  logic       rd_out
);
  initial begin
    addr_out = 8'h00;
    wr_out = 1'b0;
    wdata_out = 8'h00;
    rd_out = 1'b0;
  end
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk_in);
    addr_out = a;
    wdata_out = d;
    wr_out = 1'b1;
    @(negedge clk_in);
    wr_out = 1'b0;
    wdata_out = ~d;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge clk_in);
    addr_out = a;
    rd_out = 1'b1;
    @(negedge clk_in);
    rd_out = 1'b0;
    d = rdata_in;
  endtask
  // Pointer only, as a read in progress leaves it
  task automatic point(input logic [7:0] a);
    @(negedge clk_in);
    addr_out = a;
  endtask
endmodule
`default_nettype wire

// *** bench/light_sensor_gain_id_status_test.sv ***
// Self-checking bench for the gain, identity and status register bank.
// Assumes the host model makes every register access.
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, a) begin total_checks++; if ((a) !== (e)) begin err_count++; \
  $display("[ERR] %s exp %0h got %0h", n, e, a); end end
module light_sensor_gain_id_status_test;
  import light_sensor_pkg::*;
  logic        clk, arst_n, wr, rd, ract, done, sel_uv, irq_en, irq, nd;
  logic [7:0]  addr, wdata, rdata, d;
  logic [19:0] mvis, muv, up, lo, vis, uv;
  logic [3:0]  pst;
  logic [2:0]  gcode;
  logic [4:0]  gfac;
  int          err_count = 0, total_checks = 0, seed = 32'hA0ED44C3;
  int          egain = 1, evis = 0, euv = 0, pv, pu, enew = 0, eirq = 0, epo = 1, cnt = 0;
  int          fac[5] = '{1, 3, 6, 9, 18};
  light_sensor_regs u_light_sensor_regs (
    .SYS_CLK_IN(clk), .ARST_N_IN(arst_n), .REG_ADDR_IN(addr), .REG_WR_IN(wr),
    .REG_WDATA_IN(wdata), .REG_RD_IN(rd), .READ_ACTIVE_IN(ract), .MEAS_DONE_IN(done),
    .MEAS_VISIBLE_IN(mvis), .MEAS_UV_IN(muv), .IRQ_SELECT_UV_IN(sel_uv),
    .THRESHOLD_IRQ_ENABLE_IN(irq_en), .IRQ_PERSISTENCE_IN(pst), .THRESH_UPPER_IN(up),
    .THRESH_LOWER_IN(lo), .REG_RDATA_OUT(rdata), .GAIN_CODE_OUT(gcode),
    .GAIN_FACTOR_OUT(gfac), .VISIBLE_DATA_OUT(vis), .UV_DATA_OUT(uv), .IRQ_FLAG_OUT(irq),
    .NEW_DATA_OUT(nd));
  host_bus_model u_host_bus_model (.clk_in(clk), .rdata_in(rdata), .addr_out(addr),
    .wr_out(wr), .wdata_out(wdata), .rd_out(rd));
  // ---------------------------------------------------------------
  // Model and tasks
  // ---------------------------------------------------------------
  task automatic check;
    `CHK("vis", 20'(evis), vis)
    `CHK("uv", 20'(euv), uv)
    `CHK("new", 1'(enew), nd)
    `CHK("irq", 1'(eirq), irq)
    `CHK("gain", 3'(egain), gcode)
  endtask
  task automatic sread;
    u_host_bus_model.rd(STATUS_ADDR, d);
    `CHK("status", 8'(epo * 32 + eirq * 16 + enew * 8), d)
    {epo, eirq, enew} = '0;
    check;
  endtask
  task automatic meas(input logic [19:0] v, input logic [19:0] u);
    int s;
    @(negedge clk);
    {done, mvis, muv} = {1'b1, v, u};
    s = sel_uv ? u : v;
    // Interrupt follows raw results even while frozen
    if (irq_en && (s > up || s < lo)) cnt++;
    else cnt = 0;
    if (cnt > pst) eirq = 1;
    if (ract && addr >= FREEZE_LO_ADDR && addr <= FREEZE_HI_ADDR) begin
      pv = v;
      pu = u;
    end else begin
      evis = v;
      euv = u;
      enew = 1;
    end
    @(negedge clk);
    {done, mvis, muv} = {1'b0, ~v, ~u};
    check;
  endtask
  task automatic complete_run;
    $display("checks %0d errors %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  initial begin
    repeat (20000) @(posedge clk);
    err_count++;
    complete_run;
  end
  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  initial begin
    {arst_n, ract, done, sel_uv, irq_en, pst, mvis, muv} = '0;
    {up, lo} = {20'hC0000, 20'h40000};
    repeat (20) @(negedge clk);
    arst_n = 1'b1;
    check;
    u_host_bus_model.rd(GAIN_RANGE_ADDR, d);
    `CHK("gain rst", 8'h01, d)
    sread;
    sread;
    $display("test reset done");
    for (int i = 0; i < 8; i++) begin
      u_host_bus_model.wr(GAIN_RANGE_ADDR, 8'hF8 | 8'(i));
      if (i < 5) egain = i;
      u_host_bus_model.rd(GAIN_RANGE_ADDR, d);
      `CHK("gain rd", 8'(egain), d)
      `CHK("factor", 5'(fac[egain]), gfac)
    end
    u_host_bus_model.wr(DEVICE_ID_ADDR, 8'hFF);
    u_host_bus_model.wr(STATUS_ADDR, 8'hFF);
    u_host_bus_model.rd(DEVICE_ID_ADDR, d);
    `CHK("id", 8'h51, d)
    sread;
    u_host_bus_model.rd(8'h3F, d);
    `CHK("unmapped", 8'h00, d)
    $display("test registers done");
    repeat (3) meas(20'($random(seed)), 20'($random(seed)));
    sread;
    u_host_bus_model.point(8'h0D);
    ract = 1'b1;
    meas(20'h12345, 20'h54321);
    meas(20'h0ABCD, 20'h0DCBA);
    ract = 1'b0;
    repeat (2) @(negedge clk);
    evis = pv;
    euv = pu;
    enew = 1;
    check;
    u_host_bus_model.rd(DATA_LO_ADDR, d);
    enew = 0;
    check;
    $display("test freeze done");
    {irq_en, pst} = {1'b1, 4'h2};
    repeat (3) meas(20'hFFFFF, 20'h00000);
    sread;
    pst = 4'h1;
    for (int i = 0; i < 40; i++) begin
      sel_uv = i[0];
      irq_en = (i % 9 != 8);
      meas(20'($random(seed)), 20'($random(seed)));
      if (i % 6 == 5) sread;
    end
    $display("test interrupt done");
    complete_run;
  end
endmodule
`default_nettype wire
